// ### pkg/asr_regs.svh
// Purpose: Timing constants for the async SRAM host controller
// Assumes: 50 MHz clock; both speed grades described
// Notes:   Counts round least times up to whole cycles
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_CLK_PERIOD_PS         20000
`define ASR_CYC(ns) (((ns) * 1000 + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS)

// Times in ns, fast grade then slow grade
`define ASR_READ_CYCLE_TIME_FAST   55
`define ASR_READ_CYCLE_TIME_SLOW   70
`define ASR_ADDRESS_ACCESS_FAST    55
`define ASR_ADDRESS_ACCESS_SLOW    70
`define ASR_WE_PULSE_FAST          40
`define ASR_WE_PULSE_SLOW          50
`define ASR_WRITE_DATA_SETUP_FAST  25
`define ASR_WRITE_DATA_SETUP_SLOW  30
`define ASR_WE_TURNOFF_DELAY_FAST  20
`define ASR_WE_TURNOFF_DELAY_SLOW  25
`define ASR_DESELECT_TO_RETENTION  0

`define ASR_ADDR_W                 15
`define ASR_DATA_W                 8

`endif

// ### pkg/asr_pkg.sv
// Purpose: Types for the async SRAM host controller
// Assumes: Widths from the constants header
// Notes:   Pins travel together as one struct
`include "asr_regs.svh"
package asr_pkg;

    // User request: direction, address, write byte
    typedef struct packed {
        logic                     we;
        logic [`ASR_ADDR_W-1:0]   addr;
        logic [`ASR_DATA_W-1:0]   wdata;
    } asr_req_t;

    // Outgoing memory pins; dq_oe_n low while driving
    typedef struct packed {
        logic [`ASR_ADDR_W-1:0]   addr;
        logic                     ce_n;
        logic                     oe_n;
        logic                     we_n;
        logic [`ASR_DATA_W-1:0]   dq;
        logic                     dq_oe_n;
    } asr_pins_t;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WSET, ST_WLOW, ST_WEND, ST_STBY, ST_RECOV
    } asr_state_t;

endpackage : asr_pkg

// ### hw/asr_cycle_timer.sv
// Purpose: Down counter that marks the last cycle of a phase
// Assumes: Load value at least one
// Notes:   last_o is high in the final cycle of the count
`timescale 1ns/100ps
module asr_cycle_timer #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              last_o
);
    logic [W-1:0] cnt;                 // Cycles left in the phase

    // Last cycle decode
    assign last_o = (cnt == W'(1));

    // Load or count down to zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (load_i) begin
            cnt <= value_i;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end
endmodule : asr_cycle_timer

// ### hw/asr_host.sv
// Purpose: Host controller driving a 32K by 8 async static RAM
// Assumes: Data input synchronous to clk_i; one access at a time
// Notes:   Writes always run with OE high so no bus contention
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_host import asr_pkg::*; #(
    parameter bit FAST_GRADE = 1'b1
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   req_valid_i,
    input  wire asr_req_t               req_i,
    output logic                        ready_o,
    output logic [`ASR_DATA_W-1:0]      rdata_o,
    output logic                        rvalid_o,
    input  wire logic                   standby_i,
    output logic                        standby_ack_o,
    output asr_pins_t                   sram_o,
    input  wire logic [`ASR_DATA_W-1:0] sram_dq_i
);
    // Cycle counts for the chosen grade
    localparam int RC_CYC = FAST_GRADE ?
        `ASR_CYC(`ASR_READ_CYCLE_TIME_FAST) :
        `ASR_CYC(`ASR_READ_CYCLE_TIME_SLOW);
    localparam int AA_CYC = FAST_GRADE ?
        `ASR_CYC(`ASR_ADDRESS_ACCESS_FAST) :
        `ASR_CYC(`ASR_ADDRESS_ACCESS_SLOW);
    localparam int PW_CYC = FAST_GRADE ?
        `ASR_CYC(`ASR_WE_PULSE_FAST) : `ASR_CYC(`ASR_WE_PULSE_SLOW);
    localparam int SD_CYC = FAST_GRADE ?
        `ASR_CYC(`ASR_WRITE_DATA_SETUP_FAST) :
        `ASR_CYC(`ASR_WRITE_DATA_SETUP_SLOW);
    localparam int WL_CYC = (PW_CYC > SD_CYC) ? PW_CYC : SD_CYC;
    localparam int RD_CYC = (AA_CYC > RC_CYC) ? AA_CYC : RC_CYC;

    asr_state_t  state;              // Current phase
    asr_state_t  next_state;         // Phase after this edge
    logic        tmr_load;           // Restart phase timer
    logic [3:0]  tmr_value;          // Phase length in cycles
    logic        tmr_last;           // Final cycle of phase
    logic        take_req;           // Request accepted now
    logic        read_done;          // Read sample edge
    logic [3:0]  sel_cnt;            // Helper: cycles CE held low

    // Pin checks all run on the controller clock, quiet in reset
    default clocking cb_pins @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Request accepted only from idle with no standby asked
    assign take_req  = (state == ST_IDLE) && req_valid_i && !standby_i;
    assign read_done = (state == ST_READ) && tmr_last;

    // Next phase decode
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (standby_i)        next_state = ST_STBY;
                else if (take_req)    next_state = req_i.we ? ST_WSET
                                                            : ST_READ;
            end
            ST_READ:  if (tmr_last) next_state = ST_IDLE;
            ST_WSET:  next_state = ST_WLOW;
            ST_WLOW:  if (tmr_last) next_state = ST_WEND;
            ST_WEND:  next_state = ST_IDLE;
            ST_STBY:  if (!standby_i) next_state = ST_RECOV;
            ST_RECOV: if (tmr_last) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // Phase timer loads on entry to timed phases
    assign tmr_load  = (next_state != state) &&
                       (next_state == ST_READ || next_state == ST_WLOW ||
                        next_state == ST_RECOV);
    assign tmr_value = (next_state == ST_WLOW) ? 4'(WL_CYC) :
                       (next_state == ST_READ) ? 4'(RD_CYC) : 4'(RC_CYC);

    asr_cycle_timer #(.W(4)) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .last_o  (tmr_last)
    );

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) state <= ST_IDLE;
        else       state <= next_state;
    end

    // Pin drive; address set with or before CE falls
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sram_o <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        dq: '0, dq_oe_n: 1'b1};
        end else begin
            case (next_state)
                ST_READ: begin
                    if (take_req) sram_o.addr <= req_i.addr;
                    sram_o.ce_n    <= 1'b0;
                    sram_o.oe_n    <= 1'b0;
                    sram_o.we_n    <= 1'b1;
                    sram_o.dq_oe_n <= 1'b1;
                end
                ST_WSET: begin
                    sram_o.addr    <= req_i.addr;
                    sram_o.dq      <= req_i.wdata;
                    sram_o.ce_n    <= 1'b0;
                    sram_o.oe_n    <= 1'b1;
                    sram_o.we_n    <= 1'b1;
                    sram_o.dq_oe_n <= 1'b0;
                end
                ST_WLOW: sram_o.we_n <= 1'b0;
                ST_WEND: begin
                    sram_o.ce_n <= 1'b1;
                    sram_o.we_n <= 1'b1;
                end
                default: begin
                    sram_o.ce_n    <= 1'b1;
                    sram_o.oe_n    <= 1'b1;
                    sram_o.we_n    <= 1'b1;
                    sram_o.dq_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Read capture after address access time
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o  <= '0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= read_done;
            if (read_done) rdata_o <= sram_dq_i;
        end
    end

    // Ready and standby acknowledge from next phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o       <= 1'b0;
            standby_ack_o <= 1'b0;
        end else begin
            ready_o       <= (next_state == ST_IDLE) && !standby_i;
            standby_ack_o <= (next_state == ST_STBY);
        end
    end

    // Helper: length of each CE-low stretch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)             sel_cnt <= '0;
        else if (sram_o.ce_n)  sel_cnt <= '0;
        else if (sel_cnt != 4'hf) sel_cnt <= sel_cnt + 4'h1;
    end

    // Write ends with CE and WE rising on the same edge
    sequence s_write_end;
        $rose(sram_o.we_n) && $rose(sram_o.ce_n);
    endsequence

    // Write opens when WE falls
    sequence s_write_start;
        $fell(sram_o.we_n);
    endsequence

    // Address and data already set up as the write opens
    sequence s_write_setup;
        !sram_o.ce_n && !sram_o.dq_oe_n &&
        $stable(sram_o.dq) && $stable(sram_o.addr);
    endsequence

    // Read opens with CE falling while OE is low
    sequence s_read_start;
        $fell(sram_o.ce_n) && !sram_o.oe_n;
    endsequence

    // Read closes with CE rising and the byte captured
    sequence s_read_end;
        $rose(sram_o.ce_n) && rvalid_o;
    endsequence

    // WE only low inside a CE-low stretch
    a_write_overlap: assert property (!sram_o.we_n |-> !sram_o.ce_n)
        else $error("WE low while CE high");
    // Data still driven on the edge that ends the write
    a_data_hold: assert property (
        s_write_end |-> $stable(sram_o.dq) && !sram_o.dq_oe_n)
        else $error("Write data not held at write end");
    // CE held low for a full read cycle
    a_read_spacing: assert property (
        ($rose(sram_o.ce_n) && !$past(sram_o.oe_n))
        |-> $past(sel_cnt) >= 4'(RD_CYC - 1))
        else $error("Read cycle too short");
    // Read closes exactly one access time after it opens
    a_read_window: assert property (
        s_read_start |-> ##(RD_CYC) s_read_end)
        else $error("Read not closed after access time");
    // Writes never run with OE low
    a_write_oe_high: assert property (!sram_o.we_n |-> sram_o.oe_n)
        else $error("Write with OE low");
    // Set-up before WE falls, pulse length, joint rise
    a_write_pulse: assert property (
        s_write_start |-> s_write_setup ##(WL_CYC) s_write_end)
        else $error("Write pulse or set-up wrong");
    // Host drives only after OE has been high a cycle
    a_no_contention: assert property (
        !sram_o.dq_oe_n |-> sram_o.oe_n && $past(sram_o.oe_n))
        else $error("Host drives while device may drive");
    // Host stays off the lines during a read
    a_read_no_drive: assert property (
        !sram_o.oe_n |-> sram_o.we_n && sram_o.dq_oe_n)
        else $error("Host drives during a read");
    // Address frozen while selected
    a_addr_stable: assert property (
        (!sram_o.ce_n && !$past(sram_o.ce_n)) |-> $stable(sram_o.addr))
        else $error("Address moved while selected");
    // Memory deselected and lines released in standby
    a_standby_off: assert property (
        standby_ack_o |-> sram_o.ce_n && sram_o.dq_oe_n)
        else $error("Memory selected during standby");
    // No access for a read cycle after retention ends
    a_retention: assert property (
        $fell(standby_i) && state == ST_STBY
        |=> sram_o.ce_n ##1 sram_o.ce_n ##1 sram_o.ce_n)
        else $error("Access before recovery time");
endmodule : asr_host

// ### tb/asr_sram_model.sv
// Purpose: Behavioural 32K by 8 async static RAM facing the host
// Assumes: Pins arrive as one struct; access delay given in ns
// Notes:   A floating bus shows a toggling pattern, never old data
`timescale 1ns/100ps
module asr_sram_model import asr_pkg::*; #(
    parameter int ACC_NS = 55  // Address to data delay
) (
    input  wire logic      clk_i,
    input  wire asr_pins_t pins_i,
    output logic [7:0]     bus_o,   // Resolved data lines
    output logic           clash_o  // Both sides drive at once
);
    logic [7:0] mem [0:32767];  // No initial value
    logic [7:0] rd_val;         // Array output after access delay
    logic       flip = 1'b0;    // Float pattern phase
    // Drive only when selected, enabled and not writing
    wire drv = !pins_i.ce_n && !pins_i.oe_n
               && pins_i.we_n;
    wire wr  = !pins_i.ce_n && !pins_i.we_n;
    // Read data settles a full access time after any change
    always @(pins_i.addr or wr or bus_o)
        rd_val <= #(ACC_NS) mem[pins_i.addr];
    // Store while the write overlap lasts
    always @(wr or pins_i.addr or bus_o) begin
        if (wr) mem[pins_i.addr] = bus_o;
    end
    // Bus level from both parties' enables
    always_comb begin
        if (!pins_i.dq_oe_n) bus_o = pins_i.dq;
        else if (drv) bus_o = rd_val;
        else bus_o = flip ? 8'ha5 : 8'h5a;
        clash_o = drv && !pins_i.dq_oe_n;
    end
    always @(posedge clk_i) flip <= ~flip;
endmodule : asr_sram_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the async SRAM host controller
// Assumes: Fast grade timings, 50 MHz clock
// Notes:   A pin monitor checks strobe order on every edge once reset is released
`timescale 1ns/100ps
`include "asr_regs.svh"
module testbench import asr_pkg::*;;
    localparam int N_RD = `ASR_CYC(`ASR_ADDRESS_ACCESS_FAST); // Read edges
    localparam int N_WL = `ASR_CYC(`ASR_WE_PULSE_FAST); // WE low edges
    localparam int N_WR = N_WL + 2;  // Plus set-up and hold edges
    localparam int LIM  = 5000;  // Cycle ceiling for the run
    logic clk_i = 0, rst_i = 1, req_valid_i = 0, standby_i = 0;
    asr_req_t req_i = '0;
    logic ready_o, rvalid_o, standby_ack_o, clash;
    logic [7:0] rdata_o, bus;
    asr_pins_t sram_o;
    int err_total = 0, comparisons = 0, cyc = 0, wlow = 0, lat;
    logic pwe = 1, pce = 1;      // Strobes at the previous edge
    logic [14:0] paddr;          // Address at the previous edge
    logic [7:0]  pdq;            // Write data at the previous edge
    asr_host #(.FAST_GRADE(1'b1)) asr_host_inst (.clk_i(clk_i),
        .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .ready_o(ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .standby_i(standby_i), .standby_ack_o(standby_ack_o),
        .sram_o(sram_o), .sram_dq_i(bus));
    asr_sram_model #(.ACC_NS(55)) asr_sram_model_inst (.clk_i(clk_i),
        .pins_i(sram_o), .bus_o(bus), .clash_o(clash));
    initial forever #10 clk_i = ~clk_i;
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %0t byte %h expected %h", $time, g, e);
            err_total++;
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %0t flag %b expected %b", $time, g, e);
            err_total++;
        end
    endtask : chk1
    task automatic close_out;
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // One access; for reads, lat counts edges until data comes back
    task automatic access(input logic w, input logic [14:0] a,
                          input logic [7:0] d);
        lat = 0;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{we: w, addr: a, wdata: d};
        do @(posedge clk_i); while (ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do begin
            @(posedge clk_i);
            #1 lat++;
        end while ((w ? ready_o : rvalid_o) !== 1'b1 && lat < 20);
    endtask : access
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00);
        chk8(rdata_o, e);
        chk1(lat == N_RD, 1'b1);
    endtask : rd_chk
    // One write; ready returns after set-up, pulse and hold
    task automatic wr_chk(input logic [14:0] a, input logic [7:0] d);
        access(1'b1, a, d);
        chk1(lat == N_WR, 1'b1);
    endtask : wr_chk
    // Idle pins while reset holds
    task automatic t_reset;
        repeat (5) @(posedge clk_i);
        #1 chk1(sram_o.ce_n & sram_o.oe_n & sram_o.we_n, 1'b1);
        chk1(sram_o.dq_oe_n, 1'b1);
    endtask : t_reset
    // Corner addresses, back-to-back reads, then an overwrite
    task automatic t_wr_rd;
        logic [14:0] at [4] = '{15'h0000, 15'h7fff, 15'h1234, 15'h4321};
        logic [7:0]  dt [4] = '{8'h3c, 8'hc3, 8'h01, 8'hfe};
        foreach (at[i]) wr_chk(at[i], dt[i]);
        foreach (at[i]) rd_chk(at[i], dt[i]);
        wr_chk(15'h1234, 8'h9a);
        rd_chk(15'h1234, 8'h9a);
        rd_chk(15'h4321, 8'hfe);
    endtask : t_wr_rd
    // Retention handshake: deselect, then recover a full read cycle
    task automatic t_standby;
        int n;
        @(posedge clk_i) standby_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 chk1(standby_ack_o & sram_o.ce_n, 1'b1);
        chk1(ready_o, 1'b0);
        @(posedge clk_i) standby_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (ready_o !== 1'b1 && n < 20);
        chk1(n >= N_RD, 1'b1);
        rd_chk(15'h7fff, 8'hc3);
    endtask : t_standby
    // Pin monitor: strobe order, pulse width, bus ownership
    always @(posedge clk_i) begin
        if (!rst_i) begin
            chk1(clash, 1'b0);
            if (!sram_o.we_n) chk1(sram_o.oe_n, 1'b1);
            if (!pwe && !sram_o.we_n) chk8(sram_o.dq, pdq);
            if (!pce && !sram_o.ce_n)
                chk1(sram_o.addr == paddr, 1'b1);
            if (!pwe && sram_o.we_n) begin
                chk1(sram_o.ce_n, 1'b1);
                chk1(wlow == N_WL, 1'b1);
            end
        end
        wlow = sram_o.we_n ? 0 : wlow + 1;
        pwe = sram_o.we_n;
        pce = sram_o.ce_n;
        paddr = sram_o.addr;
        pdq = sram_o.dq;
        cyc++;
        if (cyc == LIM) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        t_reset();
        repeat (15) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_wr_rd();
        t_standby();
        close_out();
    end
endmodule : testbench
